// ### core/nqr_map.svh
// offsets, field layouts, codes and counts for the node query responder
`ifndef NQR_MAP_SVH
`define NQR_MAP_SVH
// message codes
`define NQR_CODE_PQUERY 8'h08
`define NQR_CODE_PREPLY 8'h09
`define NQR_CODE_TQUERY 8'h10
`define NQR_CODE_GENERIC 8'h01
`define NQR_CODE_DREADY 8'h02
`define NQR_CODE_DREPLY 8'h03
`define NQR_RC_GOOD 8'h00
`define NQR_RC_INVALID 8'h01
// message lengths in bytes, protocol list start index and records per frame
`define NQR_REQ_LEN 4'h8
`define NQR_DREPLY_MIN 4'h4
`define NQR_PREPLY_LEN 5'h0F
`define NQR_GENERIC_LEN 5'h05
`define NQR_DREADY_LEN 5'h0C
`define NQR_PLIST_BASE 5'h04
`define NQR_PLIST_LEN 4'hB
`define NQR_REC_LEN 5'h12
`define NQR_REC_PER_FRAME 4'h8
// register offsets
`define NQR_OFF_CTRL 8'h00
`define NQR_OFF_STATUS 8'h04
`define NQR_OFF_ENTRIES 8'h08
`define NQR_OFF_PLEN 8'h0C
`define NQR_OFF_TADDR 8'h10
`define NQR_OFF_TDATA 8'h14
`define NQR_OFF_PLIST 8'h40
`define NQR_OFF_PLIST_END 8'h6C
// field positions
`define NQR_CTRL_EN_BIT 0
`define NQR_ST_BUSY_BIT 0
`define NQR_ST_LOW_BIT 1
`define NQR_ST_HIGH_BIT 2
`define NQR_ST_WAIT_BIT 3
// reset values
`define NQR_CTRL_EN_RST 1'b1
`define NQR_ENTRIES_RST 8'h00
`define NQR_PLEN_RST 4'h0
`endif

// ### core/nqr_pkg.sv
// types shared by the node query responder
package nqr_pkg;

  typedef enum logic [1:0] {
    NQR_IDLE,
    NQR_SEND,
    NQR_WAIT
  } nqr_state_t;

  typedef enum logic [2:0] {
    MSG_PREPLY,
    MSG_GEN_BAD,
    MSG_GEN_OK,
    MSG_DREADY,
    MSG_DATA
  } nqr_msg_t;

endpackage

// ### core/nqr_table_mem.sv
// byte memory holding the configurator table records
module nqr_table_mem #(
  parameter int DEPTH = 288,
  parameter int AW = 9
) (
  // clock
  input wire logic core_clk,
  // write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // read side
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata_r
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    rdata_r <= mem[raddr];
  end

endmodule // nqr_table_mem

// ### core/nqr_responder.sv
// node query responder: protocol and table query replies
//
// What this block does
// - protocol query: code 08h, tag, return path
// - bad query field answers generic invalid reply
// - reply path taken from request return path
// - protocol reply code 09h, same port
// - protocol reply echoes request tag
// - protocol list eleven bytes, zero padded
// - standard protocol is one code byte
// - vendor entry: code plus four-byte identifier
// - protocol codes in list are distinct
// - table query: code 10h, tag, return path
// - data-ready gives byte count, offset zero
// - 18-byte records, eight per frame max
// - record layout with live flag, port-1
// - generic and data-ready replies echo tag and path, data frames path only
// - speed bits follow link speed state
//
// The address map and the plain strobed port were left to the implementer.
`include "nqr_map.svh"

module nqr_responder
  import nqr_pkg::*;
#(
  parameter int PORT_W = 2,
  parameter int MAX_ENTRIES = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // received service messages
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic [PORT_W-1:0] rx_port,
  // transmitted service messages
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic [PORT_W-1:0] tx_port,
  output logic [31:0] tx_path,
  input wire logic tx_ready,
  // link state pins
  input wire logic port_operational,
  input wire logic port_high_speed,
  output logic running_low_speed,
  output logic running_high_speed
);

  localparam int TBL_DEPTH = MAX_ENTRIES * `NQR_REC_LEN;
  localparam int TBL_AW = $clog2(TBL_DEPTH);
  localparam logic [7:0] MAX_E8 = 8'(MAX_ENTRIES);
  // worked out at int width so the product cannot wrap in five bits
  localparam int FRAME_BYTES = `NQR_REC_PER_FRAME * `NQR_REC_LEN;

  nqr_state_t state_r;
  nqr_msg_t kind_r;
  logic ctrl_en_r;
  logic [7:0] entries_r;
  logic [3:0] plen_r;
  logic [7:0] plist_r [`NQR_PLIST_LEN];
  logic [TBL_AW-1:0] tbl_waddr_r;
  logic [TBL_AW-1:0] tbl_ptr_r;
  logic [7:0] mem_rdata;
  logic [31:0] rdata_r;
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_len_r;
  logic rx_done_r;
  logic [7:0] rx_code_s;
  logic [15:0] rx_tag_s;
  logic [31:0] rx_path_s;
  logic [PORT_W-1:0] rx_port_s;
  logic [15:0] tag_r;
  logic [31:0] path_r;
  logic [PORT_W-1:0] port_r;
  logic tx_valid_r;
  logic tx_last_r;
  logic [7:0] tx_data_r;
  logic [4:0] idx_r;
  logic pend_r;
  logic [15:0] left_r;
  logic [4:0] rb_r;
  logic [2:0] frec_r;
  logic op_s1_r, op_s2_r, op_s3_r, op_r;
  logic hs_s1_r, hs_s2_r, hs_s3_r, hs_r;
  logic run_low_r, run_high_r;
  logic slot_free, start, len_ok, is_pq, is_tq, reply_ok;
  logic [4:0] msg_len;
  logic [7:0] byte_nxt;
  logic [4:0] pl_i;
  logic [15:0] byte_count;
  logic tbl_we;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  function automatic logic plist_hit(input logic [7:0] a);
    return (a >= `NQR_OFF_PLIST) && (a < `NQR_OFF_PLIST_END) &&
           (a[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] plist_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - `NQR_OFF_PLIST;
    return d[5:2];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // register port

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrl_en_r <= `NQR_CTRL_EN_RST;
      entries_r <= `NQR_ENTRIES_RST;
      plen_r <= `NQR_PLEN_RST;
    end else if (reg_we) begin
      if (reg_addr == `NQR_OFF_CTRL) begin
        ctrl_en_r <= reg_wdata[`NQR_CTRL_EN_BIT];
      end
      // clamped so the table walk never leaves the memory
      if (reg_addr == `NQR_OFF_ENTRIES) begin
        entries_r <= (reg_wdata[7:0] > MAX_E8) ? MAX_E8 : reg_wdata[7:0];
      end
      if (reg_addr == `NQR_OFF_PLEN) begin
        plen_r <= (reg_wdata[3:0] > `NQR_PLIST_LEN) ? `NQR_PLIST_LEN :
                  reg_wdata[3:0];
      end
    end
  end

  // software fills standard one-byte and five-byte vendor entries here
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int i = 0; i < `NQR_PLIST_LEN; i++) begin
        plist_r[i] <= 8'h00;
      end
    end else if (reg_we && plist_hit(reg_addr)) begin
      plist_r[plist_idx(reg_addr)] <= reg_wdata[7:0];
    end
  end

  assign tbl_we = reg_we && (reg_addr == `NQR_OFF_TDATA);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tbl_waddr_r <= '0;
    end else if (reg_we && reg_addr == `NQR_OFF_TADDR) begin
      tbl_waddr_r <= reg_wdata[TBL_AW-1:0];
    end else if (tbl_we) begin
      tbl_waddr_r <= tbl_waddr_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rdata_r <= 32'h0;
    end else if (reg_re) begin
      case (reg_addr)
        `NQR_OFF_CTRL: rdata_r <= {31'h0, ctrl_en_r};
        `NQR_OFF_STATUS: rdata_r <= {28'h0, state_r == NQR_WAIT,
                                     run_high_r, run_low_r,
                                     state_r != NQR_IDLE};
        `NQR_OFF_ENTRIES: rdata_r <= {24'h0, entries_r};
        `NQR_OFF_PLEN: rdata_r <= {28'h0, plen_r};
        `NQR_OFF_TADDR: rdata_r <= 32'(tbl_waddr_r);
        default: begin
          rdata_r <= plist_hit(reg_addr) ?
                     {24'h0, plist_r[plist_idx(reg_addr)]} : 32'h0;
        end
      endcase
    end else begin
      rdata_r <= 32'h0;
    end
  end

  nqr_table_mem #(
    .DEPTH(TBL_DEPTH),
    .AW(TBL_AW)
  ) u_mem (
    .core_clk(core_clk),
    .we(tbl_we),
    .waddr(tbl_waddr_r),
    .wdata(reg_wdata[7:0]),
    .raddr(tbl_ptr_r),
    .rdata_r(mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // link state pins, three stages, change taken once stages two and three agree

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      {op_s1_r, op_s2_r, op_s3_r, op_r} <= 4'h0;
      {hs_s1_r, hs_s2_r, hs_s3_r, hs_r} <= 4'h0;
    end else begin
      {op_s1_r, op_s2_r, op_s3_r} <= {port_operational, op_s1_r, op_s2_r};
      {hs_s1_r, hs_s2_r, hs_s3_r} <= {port_high_speed, hs_s1_r, hs_s2_r};
      if (op_s2_r == op_s3_r) begin
        op_r <= op_s3_r;
      end
      if (hs_s2_r == hs_s3_r) begin
        hs_r <= hs_s3_r;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      run_low_r <= 1'b0;
      run_high_r <= 1'b0;
    end else begin
      run_high_r <= op_r && hs_r;
      run_low_r <= op_r && !hs_r;
    end
  end

  speed_down_a: assert property (
    (!port_operational) [*6] |-> !running_high_speed && !running_low_speed)
    else $error("speed bits set while link not operational");

  speed_high_a: assert property (
    (port_operational && port_high_speed) [*6]
      |-> running_high_speed && !running_low_speed)
    else $error("high speed not reported");

  //////////////////////////////////////////////////////////////////////////
  // request receive; reserved byte one is never looked at

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rx_cnt_r <= 4'h0;
      rx_len_r <= 4'h0;
      rx_done_r <= 1'b0;
      rx_code_s <= 8'h00;
      rx_tag_s <= 16'h0;
      rx_path_s <= 32'h0;
      rx_port_s <= '0;
    end else begin
      rx_done_r <= rx_valid && rx_last;
      if (rx_valid) begin
        rx_len_r <= (rx_cnt_r == 4'hF) ? 4'hF : rx_cnt_r + 4'h1;
        rx_cnt_r <= rx_last ? 4'h0 :
                    (rx_cnt_r == 4'hF) ? 4'hF : rx_cnt_r + 4'h1;
        case (rx_cnt_r)
          4'h0: begin
            rx_code_s <= rx_data;
            rx_port_s <= rx_port;
          end
          4'h2: rx_tag_s[15:8] <= rx_data;
          4'h3: rx_tag_s[7:0] <= rx_data;
          4'h4, 4'h5, 4'h6, 4'h7: begin
            rx_path_s <= {rx_path_s[23:0], rx_data};
          end
          default: ;
        endcase
      end
    end
  end

  assign is_pq = rx_code_s == `NQR_CODE_PQUERY;
  assign is_tq = rx_code_s == `NQR_CODE_TQUERY;
  assign len_ok = rx_len_r == `NQR_REQ_LEN;
  // a fresh query while waiting for a data-reply abandons the transfer
  assign start = rx_done_r && ctrl_en_r && (is_pq || is_tq) &&
                 (state_r == NQR_IDLE || state_r == NQR_WAIT);
  // matching on tag relies on the requester keeping it unique
  assign reply_ok = rx_done_r && state_r == NQR_WAIT &&
                    rx_code_s == `NQR_CODE_DREPLY &&
                    rx_len_r >= `NQR_DREPLY_MIN && rx_tag_s == tag_r;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tag_r <= 16'h0;
      path_r <= 32'h0;
      port_r <= '0;
    end else if (start) begin
      tag_r <= rx_tag_s;
      path_r <= rx_path_s;
      port_r <= rx_port_s;
    end
  end

  path_copy_a: assert property (
    start |=> tx_path == $past(rx_path_s))
    else $error("reply path not taken from return path");

  port_copy_a: assert property (
    start |=> tx_port == $past(rx_port_s))
    else $error("reply not aimed at receiving port");

  //////////////////////////////////////////////////////////////////////////
  // reply byte generation

  assign byte_count = 16'(entries_r) * 16'(`NQR_REC_LEN);

  always_comb begin
    msg_len = `NQR_GENERIC_LEN;
    if (kind_r == MSG_PREPLY) begin
      msg_len = `NQR_PREPLY_LEN;
    end else if (kind_r == MSG_DREADY) begin
      msg_len = `NQR_DREADY_LEN;
    end
  end

  always_comb begin
    byte_nxt = 8'h00;
    pl_i = idx_r - `NQR_PLIST_BASE;
    if (idx_r == 5'h02) begin
      byte_nxt = tag_r[15:8];
    end else if (idx_r == 5'h03) begin
      byte_nxt = tag_r[7:0];
    end else if (idx_r == 5'h00) begin
      unique case (kind_r)
        MSG_PREPLY: byte_nxt = `NQR_CODE_PREPLY;
        MSG_DREADY: byte_nxt = `NQR_CODE_DREADY;
        default: byte_nxt = `NQR_CODE_GENERIC;
      endcase
    end else if (kind_r == MSG_PREPLY) begin
      if (idx_r >= `NQR_PLIST_BASE && pl_i < 5'(plen_r)) begin
        byte_nxt = plist_r[pl_i[3:0]];
      end
    end else if (kind_r == MSG_GEN_BAD && idx_r == 5'h04) begin
      byte_nxt = `NQR_RC_INVALID;
    end else if (kind_r == MSG_DREADY && idx_r >= 5'h0A) begin
      // offset bytes 4..7 stay zero, count in 8..11
      byte_nxt = (idx_r == 5'h0A) ? byte_count[15:8] :
                 byte_count[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transmit engine

  assign slot_free = !tx_valid_r || tx_ready;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= NQR_IDLE;
      kind_r <= MSG_PREPLY;
      idx_r <= 5'h0;
      tx_valid_r <= 1'b0;
      tx_last_r <= 1'b0;
      tx_data_r <= 8'h00;
      pend_r <= 1'b0;
      tbl_ptr_r <= '0;
      left_r <= 16'h0;
      rb_r <= 5'h0;
      frec_r <= 3'h0;
    end else begin
      unique case (state_r)
        NQR_IDLE, NQR_WAIT: begin
          if (start) begin
            state_r <= NQR_SEND;
            idx_r <= 5'h0;
            kind_r <= !len_ok ? MSG_GEN_BAD :
                      is_pq ? MSG_PREPLY : MSG_GEN_OK;
          end else if (reply_ok) begin
            state_r <= NQR_SEND;
            kind_r <= MSG_DATA;
            tbl_ptr_r <= '0;
            left_r <= byte_count;
            rb_r <= 5'h0;
            frec_r <= 3'h0;
            pend_r <= 1'b0;
          end
        end
        NQR_SEND: begin
          if (kind_r != MSG_DATA) begin
            if (slot_free) begin
              if (idx_r < msg_len) begin
                tx_valid_r <= 1'b1;
                tx_data_r <= byte_nxt;
                tx_last_r <= idx_r == msg_len - 5'h1;
                idx_r <= idx_r + 5'h1;
              end else begin
                tx_valid_r <= 1'b0;
                tx_last_r <= 1'b0;
                idx_r <= 5'h0;
                if (kind_r == MSG_GEN_OK) begin
                  kind_r <= MSG_DREADY;
                end else if (kind_r == MSG_DREADY) begin
                  state_r <= NQR_WAIT;
                end else begin
                  state_r <= NQR_IDLE;
                end
              end
            end
          end else if (left_r == 16'h0) begin
            if (slot_free) begin
              tx_valid_r <= 1'b0;
              tx_last_r <= 1'b0;
              state_r <= NQR_IDLE;
            end
          end else if (!pend_r) begin
            // memory read is registered, so each byte is fetched first
            pend_r <= 1'b1;
            if (slot_free) begin
              tx_valid_r <= 1'b0;
              tx_last_r <= 1'b0;
            end
          end else if (slot_free) begin
            pend_r <= 1'b0;
            tx_valid_r <= 1'b1;
            tx_data_r <= (rb_r == `NQR_REC_LEN - 5'h1) ? 8'h00 :
                         mem_rdata;
            tx_last_r <= (rb_r == `NQR_REC_LEN - 5'h1) &&
                         (frec_r == 3'(`NQR_REC_PER_FRAME - 4'h1) ||
                          left_r == 16'h1);
            tbl_ptr_r <= tbl_ptr_r + 1'b1;
            left_r <= left_r - 16'h1;
            if (rb_r == `NQR_REC_LEN - 5'h1) begin
              rb_r <= 5'h0;
              frec_r <= frec_r + 3'h1;
            end else begin
              rb_r <= rb_r + 5'h1;
            end
          end
        end
        default: state_r <= NQR_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks on the transmit side

  logic [4:0] cur_i;
  logic [7:0] fr_bytes_r;
  logic hdr_out;

  assign cur_i = idx_r - 5'h1;
  assign hdr_out = state_r == NQR_SEND && kind_r != MSG_DATA && tx_valid_r;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fr_bytes_r <= 8'h00;
    end else if (kind_r == MSG_DATA && tx_valid_r && tx_ready) begin
      fr_bytes_r <= tx_last_r ? 8'h00 : fr_bytes_r + 8'h01;
    end
  end

  sequence gen_ok_done_s;
    state_r == NQR_SEND && kind_r == MSG_GEN_OK &&
    idx_r == `NQR_GENERIC_LEN && slot_free;
  endsequence

  sequence dready_head_s;
    tx_valid_r && kind_r == MSG_DREADY && tx_data_r == `NQR_CODE_DREADY;
  endsequence

  sequence tag_hi_taken_s;
    hdr_out && cur_i == 5'h02 && tx_ready;
  endsequence

  proto_code_a: assert property (
    hdr_out && kind_r == MSG_PREPLY && cur_i == 5'h00
      |-> tx_data_r == `NQR_CODE_PREPLY)
    else $error("protocol reply code wrong");

  tag_echo_a: assert property (
    tag_hi_taken_s |=> $past(tx_data_r) == tag_r[15:8] ##0
      tx_data_r == tag_r[7:0])
    else $error("tag not echoed most significant first");

  list_pad_a: assert property (
    hdr_out && kind_r == MSG_PREPLY && cur_i >= `NQR_PLIST_BASE &&
      cur_i - `NQR_PLIST_BASE >= 5'(plen_r) |-> tx_data_r == 8'h00)
    else $error("protocol list padding not zero");

  resv_zero_a: assert property (
    hdr_out && cur_i == 5'h01 |-> tx_data_r == 8'h00)
    else $error("reserved reply byte not zero");

  bad_field_a: assert property (
    start && !len_ok |=> state_r == NQR_SEND && kind_r == MSG_GEN_BAD)
    else $error("malformed query not answered as invalid field");

  dready_next_a: assert property (
    gen_ok_done_s |-> ##2 dready_head_s)
    else $error("data-ready does not follow generic reply");

  frame_cap_a: assert property (
    fr_bytes_r < 8'(FRAME_BYTES))
    else $error("data frame longer than eight records");

  rec_tail_a: assert property (
    kind_r == MSG_DATA && pend_r && slot_free && left_r != 16'h0 &&
      rb_r == `NQR_REC_LEN - 5'h1 |=> tx_data_r == 8'h00)
    else $error("record byte 17 not zero");

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata = rdata_r;
  assign tx_valid = tx_valid_r;
  assign tx_data = tx_data_r;
  assign tx_last = tx_last_r;
  assign tx_port = port_r;
  assign tx_path = path_r;
  assign running_low_speed = run_low_r;
  assign running_high_speed = run_high_r;

endmodule // nqr_responder

// ### sim/nqr_far_node.sv
// far node model: sends service messages, sinks replies with stalls
module nqr_far_node #(
  parameter int PORT_W = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // requests toward the responder
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  output logic [PORT_W-1:0] rx_port,
  // replies from the responder
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic [PORT_W-1:0] tx_port,
  input wire logic [31:0] tx_path,
  output logic tx_ready,
  // stall control
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cap[$];
  logic lst[$];
  logic [PORT_W-1:0] seen_port;
  logic [31:0] seen_path;
  logic [1:0] ph;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    rx_port = '0;
    tx_ready = 1'b0;
    ph = 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // sink: when slow, takes one byte in four to stretch every transfer
  always @(posedge core_clk) begin
    ph <= ph + 2'h1;
    tx_ready <= rstn && (!slow || ph == 2'h2);
    if (tx_valid && tx_ready) begin
      cap.push_back(tx_data);
      lst.push_back(tx_last);
      seen_port <= tx_port;
      seen_path <= tx_path;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one byte per edge; reserved byte sent nonzero to prove it is ignored
  // caller keeps tags unique among outstanding requests
  task automatic send(input logic [7:0] code, input logic [15:0] tag,
      input logic [31:0] path, input int n, input logic [PORT_W-1:0] p);
    logic [7:0] m[9];
    m = '{code, 8'hFF, tag[15:8], tag[7:0], path[31:24], path[23:16],
      path[15:8], path[7:0], 8'h5A};
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_data <= m[i];
      rx_last <= (i == n - 1);
      rx_port <= p;
      @(posedge core_clk);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~m[n-1];
  endtask
endmodule // nqr_far_node

// ### sim/nqr_responder_tb.sv
// self-checking bench for the node query responder
`include "nqr_map.svh"
module nqr_responder_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk;
  logic rstn;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_we, reg_re;
  logic [31:0] reg_rdata;
  logic rx_valid, rx_last, tx_valid, tx_last, tx_ready, slow;
  logic [7:0] rx_data, tx_data;
  logic [1:0] rx_port, tx_port;
  logic [31:0] tx_path;
  logic port_operational, port_high_speed;
  logic running_low_speed, running_high_speed;
  logic [7:0] exp_q[$];
  logic [7:0] plist[11];
  int errors, tests_run;

  nqr_responder #(.PORT_W(2), .MAX_ENTRIES(16)) nqr_responder_inst (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_port(rx_port), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_port(tx_port),
    .tx_path(tx_path), .tx_ready(tx_ready),
    .port_operational(port_operational), .port_high_speed(port_high_speed),
    .running_low_speed(running_low_speed),
    .running_high_speed(running_high_speed));

  nqr_far_node #(.PORT_W(2)) nqr_far_node_inst (
    .core_clk(core_clk), .rstn(rstn), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_port(rx_port),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_port(tx_port), .tx_path(tx_path), .tx_ready(tx_ready),
    .slow(slow));

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // gap cycle after each strobe so no strobe is assigned twice at one edge
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_we <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_re <= 1'b0;
    @(posedge core_clk);
    check("reg_rdata", e, reg_rdata);
  endtask

  task automatic hdr(input logic [7:0] c, input logic [15:0] t);
    exp_q = '{c, 8'h00, t[15:8], t[7:0]};
  endtask

  // waits for the whole message, then compares bytes and end marker
  task automatic expect_msg(input string nm);
    int n;
    n = 0;
    while (nqr_far_node_inst.cap.size() < exp_q.size() && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 4000) begin
      errors++;
      $display("unexpected %s: expected %0d bytes, seen %0d", nm,
        exp_q.size(), nqr_far_node_inst.cap.size());
      test_done();
    end
    foreach (exp_q[i]) begin
      check(nm, {24'h0, exp_q[i]}, {24'h0, nqr_far_node_inst.cap.pop_front()});
      check("tx_last", {31'h0, i == exp_q.size() - 1},
        {31'h0, nqr_far_node_inst.lst.pop_front()});
    end
    exp_q.delete();
    $display("test %s done", nm);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    slow = 1'b0;
    port_operational = 1'b0;
    port_high_speed = 1'b0;
    errors = 0;
    tests_run = 0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    reg_rd(`NQR_OFF_CTRL, 32'h1);
    reg_rd(`NQR_OFF_ENTRIES, 32'h0);
    reg_rd(`NQR_OFF_PLEN, 32'h0);
    reg_rd(8'h30, 32'h0);
    // standard code, then vendor code with an arbitrary four-byte id
    plist = '{8'h82, 8'hFB, 8'h5A, 8'hA5, 8'h3C, 8'h01, 8'h77, 8'h77,
      8'h77, 8'h77, 8'h77};
    for (int i = 0; i < 11; i++)
      reg_wr(`NQR_OFF_PLIST + 8'(4 * i), {24'h0, plist[i]});
    reg_wr(`NQR_OFF_PLEN, 32'hF);
    reg_rd(`NQR_OFF_PLEN, 32'hB);
    reg_wr(`NQR_OFF_PLEN, 32'h6);
    nqr_far_node_inst.send(`NQR_CODE_PQUERY, 16'h1234, 32'hA1B2C3D4, 8,
      2'h2);
    hdr(`NQR_CODE_PREPLY, 16'h1234);
    for (int i = 0; i < 11; i++)
      exp_q.push_back(i < 6 ? plist[i] : 8'h00);
    expect_msg("protocol reply");
    check("tx_port", 32'h2, {30'h0, nqr_far_node_inst.seen_port});
    check("tx_path", 32'hA1B2C3D4, nqr_far_node_inst.seen_path);
    // with the enable cleared a well-formed query must draw no reply
    reg_wr(`NQR_OFF_CTRL, 32'h0);
    nqr_far_node_inst.send(`NQR_CODE_PQUERY, 16'h1236, 32'h0, 8, 2'h0);
    repeat (30) @(posedge core_clk);
    check("ignored query", 32'h0, 32'(nqr_far_node_inst.cap.size()));
    reg_wr(`NQR_OFF_CTRL, 32'h1);
    reg_rd(`NQR_OFF_CTRL, 32'h1);
    $display("test enable off done");
    // wrong length under a stalling sink
    slow <= 1'b1;
    nqr_far_node_inst.send(`NQR_CODE_PQUERY, 16'h1235, 32'h01020304, 9,
      2'h1);
    hdr(`NQR_CODE_GENERIC, 16'h1235);
    exp_q.push_back(`NQR_RC_INVALID);
    expect_msg("invalid field reply");
    check("tx_port", 32'h1, {30'h0, nqr_far_node_inst.seen_port});
    // nine records: one full frame of eight, then a frame of one
    reg_wr(`NQR_OFF_ENTRIES, 32'h9);
    reg_wr(`NQR_OFF_TADDR, 32'h0);
    for (int k = 0; k < 162; k++)
      reg_wr(`NQR_OFF_TDATA, 32'(k + 1));
    reg_rd(`NQR_OFF_TADDR, 32'hA2);
    slow <= 1'b0;
    nqr_far_node_inst.send(`NQR_CODE_TQUERY, 16'h2001, 32'h0BADF00D, 8,
      2'h3);
    hdr(`NQR_CODE_GENERIC, 16'h2001);
    exp_q.push_back(`NQR_RC_GOOD);
    expect_msg("generic good reply");
    hdr(`NQR_CODE_DREADY, 16'h2001);
    repeat (7) exp_q.push_back(8'h00);
    exp_q.push_back(8'hA2);
    expect_msg("data ready");
    check("tx_path", 32'h0BADF00D, nqr_far_node_inst.seen_path);
    repeat (2) @(posedge core_clk);
    reg_rd(`NQR_OFF_STATUS, 32'h9);
    // a stale tag must not start the transfer
    nqr_far_node_inst.send(`NQR_CODE_DREPLY, 16'h2002, 32'h0, 4, 2'h3);
    repeat (2) @(posedge core_clk);
    slow <= 1'b1;
    nqr_far_node_inst.send(`NQR_CODE_DREPLY, 16'h2001, 32'h0, 4,
      2'h3);
    for (int n = 0; n < 9; n++) begin
      for (int j = 0; j < 18; j++)
        exp_q.push_back(j == 17 ? 8'h00 : 8'(n * 18 + j + 1));
      if (n >= 7)
        expect_msg("table frame");
    end
    // high speed, low speed, not operational
    for (int s = 0; s < 3; s++) begin
      port_operational <= (s != 2);
      port_high_speed <= (s != 1);
      repeat (8) @(posedge core_clk);
      check("running_high_speed", {31'h0, s == 0},
        {31'h0, running_high_speed});
      check("running_low_speed", {31'h0, s == 1},
        {31'h0, running_low_speed});
    end
    $display("test speed bits done");
    check("spare bytes", 32'h0, 32'(nqr_far_node_inst.cap.size()));
    test_done();
  end
endmodule // nqr_responder_tb
